// File: inc/fdi_pkg.sv
package fdi_pkg;
	// fault classes, also the order of the ack bits
	localparam int CLS_CTRL = 0;
	localparam int CLS_REMOTE = 1;
	localparam int CLS_LOCAL = 2;
	localparam int CLS_MODULE = 3;
	localparam int NUM_CLS = 4;
	// set bit marks a class at the lower priority level (2)
	localparam logic [3:0] PRIO_LOW_MASK = 4'h8;
	// register byte offsets
	localparam logic [3:0] OFF_BITS = 4'h0;
	localparam logic [3:0] OFF_PARAM = 4'h4;
	localparam logic [3:0] OFF_ACK = 4'h8;
	// diagnostic bit register layout
	localparam int BIT_READY = 0;
	localparam int BIT_INHIBIT = 1;
	localparam int BIT_RUN = 2;
	localparam int BIT_SEG_OFF = 3;
	localparam int BIT_FAULT_LSB = 4;
	// diagnostic parameter register layout
	localparam int PAR_VALUE_LSB = 0;
	localparam int PAR_GROUP = 10;
	localparam int PAR_CLASS_LSB = 11;
	localparam int PAR_VALID = 13;
	// acquired configuration limits
	localparam logic [9:0] MAX_STATIONS = 10'h140;
	localparam logic [9:0] MAX_REG_WORDS = 10'h100;
	// group message numbers
	localparam logic [3:0] GRP_E1 = 4'h1;
	localparam logic [3:0] GRP_E2 = 4'h2;
	localparam logic [3:0] GRP_E4 = 4'h4;
	localparam logic [3:0] GRP_E5 = 4'h5;
	localparam logic [3:0] GRP_E6 = 4'h6;
	// glyph codes: 0..f are hex digits
	localparam logic [4:0] GL_A = 5'h0a;
	localparam logic [4:0] GL_D = 5'h0d;
	localparam logic [4:0] GL_E = 5'h0e;
	localparam logic [4:0] GL_BLANK = 5'h10;
	localparam logic [4:0] GL_DASH = 5'h11;
	localparam logic [4:0] GL_STOP_L = 5'h12;
	localparam logic [4:0] GL_STOP_R = 5'h13;
	localparam logic [9:0] DEC_TEN = 10'h00a;
	localparam logic [9:0] DEC_HUNDRED = 10'h064;
	localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

	typedef struct packed {
		logic ready;
		logic inhibit;
		logic run;
		logic seg_off;
		logic [3:0] pend;
		logic [3:0][9:0] par;
		logic grp;
		logic [3:0][3:0] older;
		logic [20:0] seg;
		logic bus_stop;
		logic outputs_reset;
		logic [31:0] rdata;
	} fdi_state_s;
endpackage

// File: src/fdi_seg_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module fdi_seg_decoder
(
	input wire logic [4:0] glyph,
	output logic [6:0] seg
);
	// segment order gfedcba, active high
	always_comb
	begin
		case (glyph)
			5'h00: seg = 7'h3f;
			5'h01: seg = 7'h06;
			5'h02: seg = 7'h5b;
			5'h03: seg = 7'h4f;
			5'h04: seg = 7'h66;
			5'h05: seg = 7'h6d;
			5'h06: seg = 7'h7d;
			5'h07: seg = 7'h07;
			5'h08: seg = 7'h7f;
			5'h09: seg = 7'h6f;
			5'h0a: seg = 7'h77;
			5'h0b: seg = 7'h7c;
			5'h0c: seg = 7'h39;
			5'h0d: seg = 7'h5e;
			5'h0e: seg = 7'h79;
			5'h0f: seg = 7'h71;
			fdi_pkg::GL_DASH: seg = 7'h40;
			fdi_pkg::GL_STOP_L: seg = 7'h46;
			fdi_pkg::GL_STOP_R: seg = 7'h70;
			default: seg = 7'h00;
		endcase
	end
endmodule
`default_nettype wire

// File: src/fdi_top.sv
// Behaviour
// - ready lamp lights only after self-test finished without error
// - host output inhibit lights inhibit lamp and resets all bus outputs
// - run lamp lit while the fieldbus is active and cycling
// - segment-off lamp lit while any bus segment is switched off
// - local bus fault: local lamp, segment number shown and stored, bus stops
// - remote bus fault: remote lamp, number reported, bus stops
// - remote lamp also accompanies group messages E1, E2, E4, E5, E6
// - group message E2 when stations exceed 320 or register words 256
// - group message E4 when a station fails to respond during acquisition
// - group message E5 when every bus group is switched off
// - module fault: module lamp, segment number shown, bus keeps running
// - module faults only from modules returning a bus acknowledgment
// - several pending faults: the highest priority one is displayed
// - equal priority: the earliest arrived fault is displayed
// - controller, remote, local are priority 1; module is priority 2
// - controller fault: controller lamp, error code shown and stored
// - display shows stop, run, address-fault symbol or fault parameter
// - host-readable registers mirror every lamp and displayed parameter
`timescale 1ns/1ps
`default_nettype none
module fdi_top
(
	input wire logic clock,
	input wire logic reset,
	input wire logic selftest_done,
	input wire logic selftest_error,
	input wire logic host_output_inhibit,
	input wire logic bus_active,
	input wire logic segment_switched_off,
	input wire logic address_invalid,
	input wire logic ctrl_fault,
	input wire logic [7:0] ctrl_code,
	input wire logic ctrl_stops_bus,
	input wire logic remote_segment_fault,
	input wire logic [9:0] remote_number,
	input wire logic local_segment_fault,
	input wire logic [9:0] local_number,
	input wire logic module_fault,
	input wire logic module_ack,
	input wire logic [9:0] module_segment,
	input wire logic cfg_acquired,
	input wire logic [9:0] station_count,
	input wire logic [9:0] register_word_count,
	input wire logic fault_gone_reacq,
	input wire logic station_no_response,
	input wire logic all_groups_off,
	input wire logic no_data_cycle,
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [31:0] reg_rdata,
	output logic lamp_ready,
	output logic lamp_inhibit,
	output logic lamp_run,
	output logic lamp_segment_off,
	output logic lamp_ctrl_fault,
	output logic lamp_remote_fault,
	output logic lamp_local_fault,
	output logic lamp_module_fault,
	output logic [6:0] seg_digit2,
	output logic [6:0] seg_digit1,
	output logic [6:0] seg_digit0,
	output logic bus_stop,
	output logic outputs_reset
);
	fdi_pkg::fdi_state_s s_ff;
	fdi_pkg::fdi_state_s nxt_s;
	logic cfg_over;
	logic group_any;
	logic [3:0] group_code;
	logic [3:0] cond;
	logic [3:0][9:0] cond_par;
	logic [3:0] ack;
	logic [2:0] win;
	logic [14:0] glyphs;
	logic [20:0] seg_now;

	// winner: {valid, class}; a class loses to a better level or an older peer
	function automatic logic [2:0] pick_f(input fdi_pkg::fdi_state_s s);
		logic [2:0] r;
		logic beaten;
		r = 3'h0;
		beaten = 1'b0;
		for (int i = 0; i < fdi_pkg::NUM_CLS; i++)
		begin
			beaten = !s.pend[i];
			for (int j = 0; j < fdi_pkg::NUM_CLS; j++)
			begin
				if (j != i && s.pend[j])
				begin
					if (!fdi_pkg::PRIO_LOW_MASK[j] && fdi_pkg::PRIO_LOW_MASK[i])
						beaten = 1'b1;
					else if (fdi_pkg::PRIO_LOW_MASK[j] == fdi_pkg::PRIO_LOW_MASK[i]
						&& s.older[j][i])
						beaten = 1'b1;
				end
			end
			if (!beaten && !r[2])
				r = {1'b1, 2'(i)};
		end
		return r;
	endfunction

	// three glyphs, leftmost first; numbers above 999 are not meaningful
	function automatic logic [14:0] glyph_f(input fdi_pkg::fdi_state_s s, input logic [2:0] w,
		input logic addr_bad);
		logic [9:0] v;
		logic [14:0] g;
		v = s.par[w[1:0]];
		g = {fdi_pkg::GL_BLANK, fdi_pkg::GL_DASH, fdi_pkg::GL_BLANK};
		if (addr_bad)
			g = {fdi_pkg::GL_BLANK, fdi_pkg::GL_A, fdi_pkg::GL_D};
		else if (w[2])
		begin
			if (w[1:0] == 2'(fdi_pkg::CLS_CTRL))
				g = {fdi_pkg::GL_BLANK, 1'b0, v[7:4], 1'b0, v[3:0]};
			else if (w[1:0] == 2'(fdi_pkg::CLS_REMOTE) && s.grp)
				g = {fdi_pkg::GL_BLANK, fdi_pkg::GL_E, 1'b0, v[3:0]};
			else
				g = {1'b0, 4'(v / fdi_pkg::DEC_HUNDRED),
					1'b0, 4'((v / fdi_pkg::DEC_TEN) % fdi_pkg::DEC_TEN),
					1'b0, 4'(v % fdi_pkg::DEC_TEN)};
		end
		else if (s.inhibit || !s.run)
			g = {fdi_pkg::GL_STOP_L, fdi_pkg::GL_BLANK, fdi_pkg::GL_STOP_R};
		return g;
	endfunction

	assign win = pick_f(s_ff);
	assign glyphs = glyph_f(s_ff, win, address_invalid);

	fdi_seg_decoder u_dec2
	(
		.glyph(glyphs[14:10]),
		.seg(seg_now[20:14])
	);
	fdi_seg_decoder u_dec1
	(
		.glyph(glyphs[9:5]),
		.seg(seg_now[13:7])
	);
	fdi_seg_decoder u_dec0
	(
		.glyph(glyphs[4:0]),
		.seg(seg_now[6:0])
	);

	always_comb
	begin
		// limits only judged once an acquisition result is offered
		cfg_over = cfg_acquired && (station_count > fdi_pkg::MAX_STATIONS
			|| register_word_count > fdi_pkg::MAX_REG_WORDS);
		group_any = fault_gone_reacq || cfg_over || station_no_response
			|| all_groups_off || no_data_cycle;
		if (fault_gone_reacq)
			group_code = fdi_pkg::GRP_E1;
		else if (cfg_over)
			group_code = fdi_pkg::GRP_E2;
		else if (station_no_response)
			group_code = fdi_pkg::GRP_E4;
		else if (all_groups_off)
			group_code = fdi_pkg::GRP_E5;
		else
			group_code = fdi_pkg::GRP_E6;
		cond[fdi_pkg::CLS_CTRL] = ctrl_fault;
		cond[fdi_pkg::CLS_REMOTE] = remote_segment_fault || group_any;
		cond[fdi_pkg::CLS_LOCAL] = local_segment_fault;
		cond[fdi_pkg::CLS_MODULE] = module_fault && module_ack;
		cond_par[fdi_pkg::CLS_CTRL] = {2'h0, ctrl_code};
		cond_par[fdi_pkg::CLS_REMOTE] = remote_segment_fault ? remote_number
			: {6'h00, group_code};
		cond_par[fdi_pkg::CLS_LOCAL] = local_number;
		cond_par[fdi_pkg::CLS_MODULE] = module_segment;
		ack = (reg_write && reg_addr == fdi_pkg::OFF_ACK) ? reg_wdata[3:0] : 4'h0;

		nxt_s = s_ff;
		nxt_s.ready = selftest_done && !selftest_error;
		nxt_s.inhibit = host_output_inhibit;
		nxt_s.outputs_reset = host_output_inhibit;
		nxt_s.run = bus_active;
		nxt_s.seg_off = segment_switched_off;
		for (int i = 0; i < fdi_pkg::NUM_CLS; i++)
		begin
			// a live condition cannot be acknowledged away, so a new set always wins
			if (cond[i] && !s_ff.pend[i])
			begin
				nxt_s.pend[i] = 1'b1;
				nxt_s.par[i] = cond_par[i];
				for (int j = 0; j < fdi_pkg::NUM_CLS; j++)
				begin
					nxt_s.older[i][j] = 1'b0;
					if (j != i)
						nxt_s.older[j][i] = s_ff.pend[j];
				end
				if (i == fdi_pkg::CLS_REMOTE)
					nxt_s.grp = !remote_segment_fault;
			end
			else if (s_ff.pend[i] && ack[i] && !cond[i])
				nxt_s.pend[i] = 1'b0;
		end
		// module faults leave the bus running
		nxt_s.bus_stop = nxt_s.pend[fdi_pkg::CLS_LOCAL] || nxt_s.pend[fdi_pkg::CLS_REMOTE]
			|| (nxt_s.pend[fdi_pkg::CLS_CTRL] && ctrl_stops_bus);
		nxt_s.seg = seg_now;
		nxt_s.rdata = fdi_pkg::RDATA_RESET;
		if (reg_read)
		begin
			case (reg_addr)
				fdi_pkg::OFF_BITS:
				begin
					nxt_s.rdata[fdi_pkg::BIT_READY] = s_ff.ready;
					nxt_s.rdata[fdi_pkg::BIT_INHIBIT] = s_ff.inhibit;
					nxt_s.rdata[fdi_pkg::BIT_RUN] = s_ff.run;
					nxt_s.rdata[fdi_pkg::BIT_SEG_OFF] = s_ff.seg_off;
					nxt_s.rdata[fdi_pkg::BIT_FAULT_LSB +: 4] = s_ff.pend;
				end
				fdi_pkg::OFF_PARAM:
				begin
					nxt_s.rdata[fdi_pkg::PAR_VALUE_LSB +: 10] = win[2] ? s_ff.par[win[1:0]]
						: 10'h000;
					nxt_s.rdata[fdi_pkg::PAR_GROUP] = win[2] && win[1:0] == 2'(fdi_pkg::CLS_REMOTE)
						&& s_ff.grp;
					nxt_s.rdata[fdi_pkg::PAR_CLASS_LSB +: 2] = win[1:0];
					nxt_s.rdata[fdi_pkg::PAR_VALID] = win[2];
				end
				default: nxt_s.rdata = fdi_pkg::RDATA_RESET;
			endcase
		end
	end

	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
			s_ff <= '0;
		else
			s_ff <= nxt_s;
	end

	assign reg_rdata = s_ff.rdata;
	assign lamp_ready = s_ff.ready;
	assign lamp_inhibit = s_ff.inhibit;
	assign lamp_run = s_ff.run;
	assign lamp_segment_off = s_ff.seg_off;
	assign lamp_ctrl_fault = s_ff.pend[fdi_pkg::CLS_CTRL];
	assign lamp_remote_fault = s_ff.pend[fdi_pkg::CLS_REMOTE];
	assign lamp_local_fault = s_ff.pend[fdi_pkg::CLS_LOCAL];
	assign lamp_module_fault = s_ff.pend[fdi_pkg::CLS_MODULE];
	assign seg_digit2 = s_ff.seg[20:14];
	assign seg_digit1 = s_ff.seg[13:7];
	assign seg_digit0 = s_ff.seg[6:0];
	assign bus_stop = s_ff.bus_stop;
	assign outputs_reset = s_ff.outputs_reset;

	a_ready_lamp: assert property (@(posedge clock) disable iff (reset)
		selftest_error |=> !lamp_ready)
		else $error("ready lamp lit despite self-test error");
	a_inhibit_outputs: assert property (@(posedge clock) disable iff (reset)
		host_output_inhibit |=> lamp_inhibit && outputs_reset)
		else $error("inhibit did not reset outputs");
	a_run_lamp: assert property (@(posedge clock) disable iff (reset)
		!bus_active ##1 !bus_active |=> !lamp_run && !$past(lamp_run))
		else $error("run lamp lit on idle bus");
	a_segment_off: assert property (@(posedge clock) disable iff (reset)
		segment_switched_off |=> lamp_segment_off)
		else $error("segment-off lamp missing");
	a_local_stop: assert property (@(posedge clock) disable iff (reset)
		local_segment_fault && !lamp_local_fault |=> lamp_local_fault && bus_stop
		&& s_ff.par[fdi_pkg::CLS_LOCAL] == $past(local_number))
		else $error("local fault not latched with stop");
	a_cfg_limit: assert property (@(posedge clock) disable iff (reset)
		cfg_acquired && station_count > fdi_pkg::MAX_STATIONS && !remote_segment_fault
		&& !fault_gone_reacq && !lamp_remote_fault
		|=> lamp_remote_fault && s_ff.par[fdi_pkg::CLS_REMOTE] == 10'(fdi_pkg::GRP_E2))
		else $error("configuration limit message missing");
	a_module_ack: assert property (@(posedge clock) disable iff (reset)
		!module_ack && !lamp_module_fault |=> !lamp_module_fault)
		else $error("module fault without bus acknowledgment");
	a_module_runs: assert property (@(posedge clock) disable iff (reset)
		!lamp_ctrl_fault && !lamp_local_fault && !lamp_remote_fault |-> !bus_stop)
		else $error("bus stopped for module fault alone");
	a_priority_pick: assert property (@(posedge clock) disable iff (reset)
		s_ff.pend[fdi_pkg::CLS_MODULE] && s_ff.pend[fdi_pkg::CLS_LOCAL]
		|-> win[1:0] != 2'(fdi_pkg::CLS_MODULE))
		else $error("module fault shown over priority 1 fault");
	a_fault_latched: assert property (@(posedge clock) disable iff (reset)
		lamp_local_fault && !(reg_write && reg_addr == fdi_pkg::OFF_ACK)
		|=> lamp_local_fault)
		else $error("fault dropped without acknowledgment");
	a_read_slot: assert property (@(posedge clock) disable iff (reset)
		!reg_read |=> reg_rdata == fdi_pkg::RDATA_RESET)
		else $error("read data outside the answer cycle");
	// the checks below, except a_older_first (same cycle), look one edge after the cause, where the registered answer stands
	a_remote_stop: assert property (@(posedge clock) disable iff (reset)
		remote_segment_fault && !lamp_remote_fault |=> lamp_remote_fault && bus_stop
		&& s_ff.par[fdi_pkg::CLS_REMOTE] == $past(remote_number))
		else $error("remote fault not latched with stop");
	a_group_lamp: assert property (@(posedge clock) disable iff (reset)
		group_any && !remote_segment_fault && !lamp_remote_fault
		|=> lamp_remote_fault && s_ff.grp)
		else $error("group message without remote lamp");
	a_word_limit: assert property (@(posedge clock) disable iff (reset)
		cfg_acquired && register_word_count > fdi_pkg::MAX_REG_WORDS && !remote_segment_fault
		&& !fault_gone_reacq && !lamp_remote_fault
		|=> lamp_remote_fault && s_ff.par[fdi_pkg::CLS_REMOTE] == 10'(fdi_pkg::GRP_E2))
		else $error("register word limit message missing");
	a_no_answer: assert property (@(posedge clock) disable iff (reset)
		station_no_response && !fault_gone_reacq && !cfg_over && !remote_segment_fault
		&& !lamp_remote_fault |=> s_ff.par[fdi_pkg::CLS_REMOTE] == 10'(fdi_pkg::GRP_E4))
		else $error("undetectable configuration message missing");
	a_groups_off: assert property (@(posedge clock) disable iff (reset)
		all_groups_off && !fault_gone_reacq && !cfg_over && !station_no_response
		&& !remote_segment_fault && !lamp_remote_fault
		|=> s_ff.par[fdi_pkg::CLS_REMOTE] == 10'(fdi_pkg::GRP_E5))
		else $error("all groups off message missing");
	a_module_latch: assert property (@(posedge clock) disable iff (reset)
		module_fault && module_ack && !lamp_module_fault |=> lamp_module_fault)
		else $error("acknowledged module fault not latched");
	a_older_first: assert property (@(posedge clock) disable iff (reset)
		!s_ff.pend[fdi_pkg::CLS_CTRL] && s_ff.pend[fdi_pkg::CLS_REMOTE]
		&& s_ff.pend[fdi_pkg::CLS_LOCAL] && s_ff.older[fdi_pkg::CLS_REMOTE][fdi_pkg::CLS_LOCAL]
		|-> win == {1'b1, 2'(fdi_pkg::CLS_REMOTE)})
		else $error("later fault shown over an older peer");
	a_ctrl_latch: assert property (@(posedge clock) disable iff (reset)
		ctrl_fault && !lamp_ctrl_fault |=> lamp_ctrl_fault
		&& s_ff.par[fdi_pkg::CLS_CTRL] == {2'h0, $past(ctrl_code)})
		else $error("controller fault not latched with its code");
	a_stop_glyph: assert property (@(posedge clock) disable iff (reset)
		!address_invalid && !win[2] && (lamp_inhibit || !lamp_run)
		|=> seg_digit2 == 7'h46 && seg_digit1 == 7'h00 && seg_digit0 == 7'h70)
		else $error("stop symbol missing");
	a_addr_glyph: assert property (@(posedge clock) disable iff (reset)
		address_invalid |=> seg_digit2 == 7'h00 && seg_digit1 == 7'h77 && seg_digit0 == 7'h5e)
		else $error("address fault symbol missing");
	a_bits_mirror: assert property (@(posedge clock) disable iff (reset)
		reg_read && reg_addr == fdi_pkg::OFF_BITS
		|=> reg_rdata[fdi_pkg::BIT_READY] == $past(lamp_ready)
		&& reg_rdata[fdi_pkg::BIT_FAULT_LSB + 3] == $past(lamp_module_fault))
		else $error("bit register does not mirror the lamps");
	a_ack_clears: assert property (@(posedge clock) disable iff (reset)
		lamp_local_fault && ack[fdi_pkg::CLS_LOCAL] && !local_segment_fault
		|=> !lamp_local_fault)
		else $error("acknowledged fault not cleared");
endmodule
`default_nettype wire

// File: verif/fdi_field_model.sv
`timescale 1ns/1ps
`default_nettype none
// far side: host plc and fieldbus segments, behavioural
module fdi_field_model
(
	input wire logic clock,
	input wire logic reset,
	input wire logic stop_req,
	input wire logic cycle_req,
	input wire logic bus_stop,
	output logic host_output_inhibit,
	output logic bus_active
);
	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			host_output_inhibit <= 1'b0;
			bus_active <= 1'b0;
		end
		else
		begin
			host_output_inhibit <= stop_req;
			// a stopped bus no longer cycles, so host io is not touched
			bus_active <= cycle_req && !bus_stop;
		end
	end
endmodule
`default_nettype wire

// File: verif/tb_fdi_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_fdi_top;
	localparam logic [6:0] SEG7 [16] = '{7'h3f, 7'h06, 7'h5b, 7'h4f, 7'h66, 7'h6d, 7'h7d, 7'h07,
		7'h7f, 7'h6f, 7'h77, 7'h7c, 7'h39, 7'h5e, 7'h79, 7'h71};
	// rows: done err stop cycle seg_off | ready inhibit run seg_off outputs_reset
	localparam logic [9:0] ROWS [6] = '{10'h000, 10'h254, 10'h366, 10'h299, 10'h1ef, 10'h276};
	localparam logic [3:0] GNUM [5] = '{4'h1, 4'h2, 4'h4, 4'h5, 4'h6};
	logic clock = 0, reset = 1, done = 0, serr = 0, stop_req = 0, cycle_req = 0, soff = 0;
	logic addr_bad = 0, cf = 0, csb = 0, rf = 0, lf = 0, mf = 0, mack = 0, wrd_big = 0, acq = 1;
	logic [4:0] gsel = 0;
	logic [3:0] reg_addr = 0;
	logic [31:0] reg_wdata = 0;
	logic reg_write = 0, reg_read = 0;
	logic [9:0] rnum = 0, lnum = 0, mseg = 0;
	logic inh, bact, bus_stop, ores;
	logic [31:0] reg_rdata;
	logic l_rdy, l_inh, l_run, l_soff, l_ctrl, l_rem, l_loc, l_mod;
	logic [6:0] d2, d1, d0;
	int num_errors = 0, num_checks = 0, cyc = 0;
	always #5 clock = ~clock;
	fdi_field_model far (.clock(clock), .reset(reset), .stop_req(stop_req), .cycle_req(cycle_req),
		.bus_stop(bus_stop), .host_output_inhibit(inh), .bus_active(bact));
	fdi_top dut (.clock(clock), .reset(reset), .selftest_done(done), .selftest_error(serr),
		.host_output_inhibit(inh), .bus_active(bact), .segment_switched_off(soff),
		.address_invalid(addr_bad), .ctrl_fault(cf), .ctrl_code(8'hbd), .ctrl_stops_bus(csb),
		.remote_segment_fault(rf), .remote_number(rnum), .local_segment_fault(lf),
		.local_number(lnum), .module_fault(mf), .module_ack(mack), .module_segment(mseg),
		.cfg_acquired(acq), .station_count(gsel[1] ? 10'h141 : 10'h140),
		.register_word_count(wrd_big ? 10'h101 : 10'h100), .fault_gone_reacq(gsel[0]),
		.station_no_response(gsel[2]), .all_groups_off(gsel[3]), .no_data_cycle(gsel[4]),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
		.reg_rdata(reg_rdata), .lamp_ready(l_rdy), .lamp_inhibit(l_inh), .lamp_run(l_run),
		.lamp_segment_off(l_soff), .lamp_ctrl_fault(l_ctrl), .lamp_remote_fault(l_rem),
		.lamp_local_fault(l_loc), .lamp_module_fault(l_mod), .seg_digit2(d2), .seg_digit1(d1),
		.seg_digit0(d0), .bus_stop(bus_stop), .outputs_reset(ores));
	task automatic conclude();
		if (num_errors == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic settle();
		repeat (4) @(posedge clock);
		#1;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, input logic [31:0] exp, input string name);
		@(posedge clock);
		reg_read <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_read <= 1'b0;
		#1;
		check(name, reg_rdata, exp);
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clock);
		reg_write <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_write <= 1'b0;
	endtask
	task automatic digits(input logic [6:0] a, input logic [6:0] b, input logic [6:0] c);
		check("display", {d2, d1, d0}, {a, b, c});
	endtask
	always @(posedge clock)
	begin
		cyc <= cyc + 1;
		if (cyc == 5000)
		begin
			num_errors++;
			conclude();
		end
	end
	initial
	begin
		repeat (6) @(posedge clock);
		check("reset lamps", {l_rdy, l_run, l_loc, bus_stop, d1}, 32'h0000_0000);
		reset <= 1'b0;
		for (int i = 0; i < 6; i++)
		begin
			{done, serr, stop_req, cycle_req, soff} <= ROWS[i][9:5];
			settle();
			check("ready", l_rdy, ROWS[i][4]);
			check("inhibit", {l_inh, ores}, {ROWS[i][3], ROWS[i][0]});
			check("run", l_run, ROWS[i][2]);
			check("seg_off", l_soff, ROWS[i][1]);
			rd(4'h0, {28'h0000_000, ROWS[i][1], ROWS[i][2], ROWS[i][3], ROWS[i][4]}, "bits");
			if (ROWS[i][2] && !ROWS[i][3])
				digits(7'h00, 7'h40, 7'h00);
			else
				digits(7'h46, 7'h00, 7'h70);
		end
		rd(4'hc, 32'h0000_0000, "unmapped");
		addr_bad <= 1'b1;
		settle();
		check("addr glyph", {d2, d1, d0}, {7'h00, 7'h77, 7'h5e});
		addr_bad <= 1'b0;
		// module fault without acknowledgment must stay silent
		mf <= 1'b1;
		mseg <= 10'h007;
		settle();
		check("mod no ack", l_mod, 1'b0);
		lf <= 1'b1;
		lnum <= 10'h00c;
		mack <= 1'b1;
		settle();
		check("local", {l_loc, l_mod, bus_stop}, 3'h7);
		digits(SEG7[0], SEG7[1], SEG7[2]);
		rd(4'h4, 32'h0000_300c, "param local");
		wr(4'h8, 32'h0000_0004);
		settle();
		check("ack held", l_loc, 1'b1);
		lf <= 1'b0;
		wr(4'h8, 32'h0000_0004);
		settle();
		check("module only", {l_loc, l_mod, bus_stop}, 3'h2);
		digits(SEG7[0], SEG7[0], SEG7[7]);
		mf <= 1'b0;
		wr(4'h8, 32'h0000_0008);
		rf <= 1'b1;
		rnum <= 10'h005;
		@(posedge clock);
		lf <= 1'b1;
		settle();
		check("remote", {l_rem, l_loc, bus_stop}, 3'h7);
		digits(SEG7[0], SEG7[0], SEG7[5]);
		rd(4'h4, 32'h0000_2805, "param remote");
		{rf, lf} <= 2'b00;
		wr(4'h8, 32'h0000_0006);
		settle();
		cf <= 1'b1;
		settle();
		check("ctrl", {l_ctrl, l_rem, bus_stop}, 3'h4);
		check("ctrl hex", {d2, d1, d0}, {7'h00, SEG7[11], SEG7[13]});
		rd(4'h4, 32'h0000_20bd, "param ctrl");
		csb <= 1'b1;
		settle();
		check("ctrl stop", {l_ctrl, bus_stop}, 2'h3);
		{cf, csb} <= 2'b00;
		wr(4'h8, 32'h0000_0001);
		settle();
		check("ctrl clear", l_ctrl, 1'b0);
		wrd_big <= 1'b0;
		settle();
		check("limits", l_rem, 1'b0);
		for (int i = 0; i < 5; i++)
		begin
			gsel <= 5'h01 << i;
			settle();
			check("group lamp", l_rem, 1'b1);
			digits(7'h00, SEG7[14], SEG7[GNUM[i]]);
			rd(4'h4, {18'h0_0000, 4'hb, 6'h00, GNUM[i]}, "param group");
			gsel <= 5'h00;
			wr(4'h8, 32'h0000_0002);
			settle();
		end
		wrd_big <= 1'b1;
		settle();
		check("words limit", {l_rem, d0}, {1'b1, SEG7[2]});
		// mid-run reset drops the latch; the live limit condition latches it again
		reset <= 1'b1;
		@(posedge clock);
		#1;
		check("mid reset", {l_rem, bus_stop, l_run, d0}, 10'h000);
		reset <= 1'b0;
		settle();
		check("relatch", {l_rem, d0}, {1'b1, SEG7[2]});
		acq <= 1'b0;
		wr(4'h8, 32'h0000_0002);
		settle();
		check("not acquired", l_rem, 1'b0);
		conclude();
	end
endmodule
`default_nettype wire
